// ==== dv/adpd_chk.sv ====
/*
 Checker for the power-down and coding block: bus between both ends
 and the converter's power outputs.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module adpd_chk (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic hw_shutdown_n,
	input wire logic dev_data_oe_n,
	input wire logic int_n,
	input wire adpd_pkg::adpd_mode_t mode_out,
	input wire logic bandgap_on_out,
	input wire logic ref_buf_on_out,
	input wire logic conv_active_out
);
	import adpd_pkg::*;
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	// ==========================================================
	// Power state
	property p_reset;
		disable iff (1'b0) reset_in |=> int_n && mode_out == ADPD_MODE_RUN;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_bandgap;
		bandgap_on_out;
	endproperty
	a_bandgap: assert property (p_bandgap) else $error("bandgap off");
	property p_refbuf;
		ref_buf_on_out == (mode_out != ADPD_MODE_FULL);
	endproperty
	a_refbuf: assert property (p_refbuf) else $error("ref buffer state");
	property p_pd_idle;
		mode_out != ADPD_MODE_RUN |-> !conv_active_out;
	endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("busy in power-down");
	property p_hw_shutdown_n;
		!hw_shutdown_n |-> ##[1:6] (mode_out == ADPD_MODE_FULL && !conv_active_out);
	endproperty
	a_hw_shutdown_n: assert property (p_hw_shutdown_n) else $error("shutdown not taken");
	property p_wake;
		mode_out != ADPD_MODE_RUN && hw_shutdown_n && !cs_n && $fell(wr_n)
			|-> ##[1:8] mode_out == ADPD_MODE_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on write");
	// ==========================================================
	// Bus and interrupt
	property p_rd_pd;
		mode_out != ADPD_MODE_RUN && !cs_n && $fell(rd_n) |-> ##[1:8] !dev_data_oe_n;
	endproperty
	a_rd_pd: assert property (p_rd_pd) else $error("no read in power-down");
	property p_int_rd;
		!int_n && !cs_n && $fell(rd_n) |-> ##[1:8] int_n;
	endproperty
	a_int_rd: assert property (p_int_rd) else $error("int not released by read");
	property p_int_wr;
		!int_n && $rose(wr_n) |-> ##[1:8] int_n;
	endproperty
	a_int_wr: assert property (p_int_wr) else $error("int not released by write");
endmodule : adpd_chk

// ==== dv/adpd_tb.sv ====
/*
 Testbench: host and converter ends joined by the bus interface,
 driven over Avalon-MM, with the checker beside the interface.
 Assumes the design sources and adpd_chk are compiled first.
*/
`timescale 1ns/100ps
`include "adpd_params.svh"
module tb;
	import adpd_pkg::*;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [11:0] sample = 12'h000;
	logic bandgap_on, ref_buf_on, conv_active, int_clk_sel;
	adpd_mode_t mode;
	logic [31:0] rd;
	int errors = 0;
	int cmp_count = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	adpd_bus_if bus ();
	adpd_device u_adpd_device (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.clk_en_in(1'b1), .bus(bus), .sample_in(sample),
		.bandgap_on_out(bandgap_on), .ref_buf_on_out(ref_buf_on),
		.conv_active_out(conv_active), .int_clk_sel_out(int_clk_sel),
		.mode_out(mode));
	adpd_host u_adpd_host (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.clk_en_in(1'b1), .bus(bus), .avs_address_in(avs_address),
		.avs_read_in(avs_read), .avs_write_in(avs_write),
		.avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest), .irq_out(irq));
	adpd_chk u_adpd_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
		.hw_shutdown_n(bus.hw_shutdown_n), .dev_data_oe_n(bus.dev_data_oe_n),
		.int_n(bus.int_n), .mode_out(mode), .bandgap_on_out(bandgap_on),
		.ref_buf_on_out(ref_buf_on), .conv_active_out(conv_active));
	// ==========================================================
	// Shared tasks
	task test_done;
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask : chk
	task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do
			@(posedge clk_sys_in);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av
	task wait_int;
		repeat (4) @(negedge clk_sys_in);
		while (bus.int_n !== 1'b0)
			@(negedge clk_sys_in);
		repeat (2) @(negedge clk_sys_in);
	endtask : wait_int
	task conv(input logic [7:0] b);
		av(1'b1, `ADPD_REG_CTRL, {23'h0, 1'b1, b});
		av(1'b1, `ADPD_REG_CMD, 32'h0);
		wait_int;
	endtask : conv
	// ==========================================================
	// Scenarios
	task t_reset;
		@(negedge clk_sys_in);
		chk("int_n", 32'h1, bus.int_n);
		chk("mode", ADPD_MODE_RUN, mode);
		chk("clk_sel", 32'h0, int_clk_sel);
		av(1'b0, `ADPD_REG_MASK, 32'h0);
		chk("mask", 32'h0, rd);
		av(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask : t_reset
	task t_modes;
		conv(8'h40);
		chk("int_clk", 32'h1, int_clk_sel);
		conv(8'h00);
		chk("ext_clk", 32'h0, int_clk_sel);
		conv(8'h80);
		chk("standby", ADPD_MODE_STANDBY, mode);
		chk("stby_pwr", 32'h3, {bandgap_on, ref_buf_on});
		chk("clk_kept", 32'h0, int_clk_sel);
		conv(8'hc0);
		chk("full", ADPD_MODE_FULL, mode);
		chk("full_pwr", 32'h2, {bandgap_on, ref_buf_on});
		conv(8'h80);
	endtask : t_modes
	task t_coding;
		logic [11:0] s [4] = '{12'h0a5, 12'h823, 12'h123, 12'hfff};
		logic [7:0] c [4] = '{8'h40, 8'h48, 8'h48, 8'hc0};
		logic [11:0] e [4] = '{12'h0a5, 12'h023, 12'h923, 12'hfff};
		for (int i = 0; i < 4; i++) begin
			sample <= s[i];
			conv(c[i]);
			av(1'b0, `ADPD_REG_CMD, 32'h0);
			chk("result", {20'h0, e[i]}, {20'h0, rd[11:0]});
			chk("int_rel", 32'h1, bus.int_n);
		end
		chk("stay_pd", ADPD_MODE_FULL, mode);
	endtask : t_coding
	task t_auto;
		repeat (2) begin
			av(1'b1, `ADPD_REG_CTRL, 32'h180);
			av(1'b1, `ADPD_REG_CMD, 32'h0);
			repeat (4) @(negedge clk_sys_in);
			chk("busy", 32'h1, conv_active);
			chk("run", ADPD_MODE_RUN, mode);
			wait_int;
			chk("auto_pd", ADPD_MODE_STANDBY, mode);
		end
	endtask : t_auto
	task t_hw_shutdown_n;
		av(1'b1, `ADPD_REG_CTRL, 32'h140);
		av(1'b1, `ADPD_REG_CMD, 32'h0);
		av(1'b1, `ADPD_REG_CTRL, 32'h040);
		repeat (8) @(negedge clk_sys_in);
		chk("hw_shutdown_n", ADPD_MODE_FULL, mode);
		chk("aborted", 32'h0, conv_active);
		chk("buf_off", 32'h0, ref_buf_on);
		repeat (40) @(negedge clk_sys_in);
		chk("no_result", 32'h1, bus.int_n);
		conv(8'h40);
		chk("wake", ADPD_MODE_RUN, mode);
	endtask : t_hw_shutdown_n
	task t_irq;
		av(1'b1, `ADPD_REG_STATUS, 32'h3);
		av(1'b1, `ADPD_REG_MASK, 32'h1);
		conv(8'h40);
		repeat (4) @(negedge clk_sys_in);
		chk("irq", 32'h1, irq);
		av(1'b1, `ADPD_REG_MASK, 32'h0);
		repeat (2) @(negedge clk_sys_in);
		chk("irq_mask", 32'h0, irq);
		av(1'b0, `ADPD_REG_CMD, 32'h0);
		av(1'b0, `ADPD_REG_STATUS, 32'h0);
		chk("status", 32'h3, rd);
		av(1'b1, `ADPD_REG_STATUS, 32'h3);
		av(1'b0, `ADPD_REG_STATUS, 32'h0);
		chk("status_clr", 32'h0, rd);
	endtask : t_irq
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		t_reset;
		t_modes;
		t_coding;
		t_auto;
		t_hw_shutdown_n;
		t_irq;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		chk("watchdog", 32'h0, 32'h1);
		test_done;
	end
endmodule : tb

// ==== logic/adpd_bus_if.sv ====
/*
 Parallel bus between host and converter: 8-bit data, write and read
 strobes, chip select, interrupt, shutdown.
 Assumes both ends share clk_sys_in; data runs on separate host_data and dev_data buses.
*/
`timescale 1ns/100ps
interface adpd_bus_if;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic hben;
	logic [7:0] host_data;
	logic [7:0] dev_data;
	logic dev_data_oe_n;
	logic int_n;
	logic hw_shutdown_n;
	modport dev (
		input cs_n, wr_n, rd_n, hben, host_data, hw_shutdown_n,
		output dev_data, dev_data_oe_n, int_n
	);
	modport host (
		output cs_n, wr_n, rd_n, hben, host_data, hw_shutdown_n,
		input dev_data, dev_data_oe_n, int_n
	);
endinterface : adpd_bus_if

// ==== logic/adpd_device.sv ====
/*
 Converter end: control byte decode, power modes, conversion timing,
 result coding and interrupt.
 Assumes bus pins come asynchronously; control pins pass three flip-flops and a filter register, host_data two; the
 sample arrives as a 12-bit offset-binary value on sample_in.
*/
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "adpd_params.svh"
module adpd_device #(
	parameter int ACQ_CYCLES = `ADPD_ACQ_CYCLES,
	parameter int CONV_CYCLES = `ADPD_CONV_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	adpd_bus_if.dev bus,
	input wire logic [11:0] sample_in,
	output logic bandgap_on_out,
	output logic ref_buf_on_out,
	output logic conv_active_out,
	output logic int_clk_sel_out,
	output adpd_pkg::adpd_mode_t mode_out
);
	import adpd_pkg::*;

	// ==========================================
	// Pin synchronisers
	localparam int NS = 5;
	logic [NS-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
	logic [NS-1:0] nxt_s1, nxt_pin;
	logic [7:0] d1_ff, d2_ff;
	logic cs_n, wr_n, rd_n, hben, sd_n;
	always_comb begin
		nxt_s1 = {bus.cs_n, bus.wr_n, bus.rd_n, bus.hben, bus.hw_shutdown_n};
		nxt_pin = pin_ff;
		for (int i = 0; i < NS; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_pin[i] = s3_ff[i];
			end
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			s1_ff <= 5'h1f;
			s2_ff <= 5'h1f;
			s3_ff <= 5'h1f;
			pin_ff <= 5'h1f;
			d1_ff <= 8'h00;
			d2_ff <= 8'h00;
		end else if (clk_en_in) begin
			s1_ff <= nxt_s1;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			pin_ff <= nxt_pin;
			d1_ff <= bus.host_data;
			d2_ff <= d1_ff;
		end
	end
	assign {cs_n, wr_n, rd_n, hben, sd_n} = pin_ff;

	// ==========================================
	// Control and conversion
	logic wr_q_ff, rd_q_ff;
	logic wr_fall, wr_rise, rd_fall;
	adpd_dev_t st_ff, nxt_st;
	adpd_mode_t mode_ff, nxt_mode;
	logic pend_pd_ff, nxt_pend_pd;
	logic pd_full_ff, nxt_pd_full;
	logic intclk_ff, nxt_intclk;
	logic bip_ff, nxt_bip;
	logic acq_ext_ff, nxt_acq_ext;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [11:0] res_ff, nxt_res;
	logic int_n_ff, nxt_int_n;
	logic [1:0] pm;
	assign wr_fall = wr_q_ff & ~wr_n & ~cs_n;
	assign wr_rise = ~wr_q_ff & wr_n & ~cs_n;
	assign rd_fall = rd_q_ff & ~rd_n & ~cs_n;
	assign pm = {d2_ff[`ADPD_CTL_PM_HI], d2_ff[`ADPD_CTL_PM_LO]};

	function automatic logic [11:0] code_of(input logic [11:0] s,
			input logic bip);
		code_of = bip ? {~s[11], s[10:0]} : s;
	endfunction : code_of

	always_comb begin
		nxt_st = st_ff;
		nxt_mode = mode_ff;
		nxt_pend_pd = pend_pd_ff;
		nxt_pd_full = pd_full_ff;
		nxt_intclk = intclk_ff;
		nxt_bip = bip_ff;
		nxt_acq_ext = acq_ext_ff;
		nxt_cnt = cnt_ff;
		nxt_res = res_ff;
		nxt_int_n = int_n_ff;
		if (wr_fall && mode_ff != ADPD_MODE_RUN) begin
			nxt_mode = ADPD_MODE_RUN;
		end
		if (rd_fall) begin
			nxt_int_n = 1'b1;
		end
		case (st_ff)
			ADPD_DEV_ACQ: begin
				if (!acq_ext_ff) begin
					if (cnt_ff == 8'h00) begin
						nxt_st = ADPD_DEV_CONV;
						nxt_cnt = 8'(CONV_CYCLES - 1);
					end else begin
						nxt_cnt = cnt_ff - 8'h01;
					end
				end
			end
			ADPD_DEV_CONV: begin
				if (cnt_ff == 8'h00) begin
					nxt_st = ADPD_DEV_IDLE;
					nxt_res = code_of(sample_in, bip_ff);
					nxt_int_n = 1'b0;
					if (pend_pd_ff) begin
						nxt_mode = pd_full_ff ? ADPD_MODE_FULL
							: ADPD_MODE_STANDBY;
						nxt_pend_pd = 1'b0;
					end
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			default: begin
			end
		endcase
		if (wr_rise) begin
			nxt_int_n = 1'b1;
			nxt_bip = d2_ff[`ADPD_CTL_BIP];
			nxt_acq_ext = d2_ff[`ADPD_CTL_ACQ];
			nxt_pend_pd = pm[1];
			nxt_pd_full = pm[0];
			if (!pm[1]) begin
				nxt_intclk = pm[0];
			end
			if (st_ff == ADPD_DEV_ACQ && acq_ext_ff
					&& !d2_ff[`ADPD_CTL_ACQ]) begin
				nxt_st = ADPD_DEV_CONV;
				nxt_cnt = 8'(CONV_CYCLES - 1);
			end else begin
				nxt_st = ADPD_DEV_ACQ;
				nxt_cnt = 8'(ACQ_CYCLES - 1);
			end
		end
		if (!sd_n) begin
			nxt_st = ADPD_DEV_IDLE;
			nxt_mode = ADPD_MODE_FULL;
			nxt_pend_pd = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			wr_q_ff <= 1'b1;
			rd_q_ff <= 1'b1;
			st_ff <= ADPD_DEV_IDLE;
			mode_ff <= ADPD_MODE_RUN;
			pend_pd_ff <= 1'b0;
			pd_full_ff <= 1'b0;
			intclk_ff <= 1'b0;
			bip_ff <= 1'b0;
			acq_ext_ff <= 1'b0;
			cnt_ff <= 8'h00;
			res_ff <= 12'h000;
			int_n_ff <= 1'b1;
		end else if (clk_en_in) begin
			wr_q_ff <= wr_n;
			rd_q_ff <= rd_n;
			st_ff <= nxt_st;
			mode_ff <= nxt_mode;
			pend_pd_ff <= nxt_pend_pd;
			pd_full_ff <= nxt_pd_full;
			intclk_ff <= nxt_intclk;
			bip_ff <= nxt_bip;
			acq_ext_ff <= nxt_acq_ext;
			cnt_ff <= nxt_cnt;
			res_ff <= nxt_res;
			int_n_ff <= nxt_int_n;
		end
	end

	// ==========================================
	// Outputs
	logic [7:0] dout_ff, nxt_dout;
	logic oe_n_ff, nxt_oe_n;
	logic bg_ff, buf_ff, act_ff;
	always_comb begin
		nxt_oe_n = ~(~cs_n & ~rd_n);
		nxt_dout = hben ? {{4{bip_ff & res_ff[11]}}, res_ff[11:8]}
			: res_ff[7:0];
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			dout_ff <= 8'h00;
			oe_n_ff <= 1'b1;
			bg_ff <= 1'b1;
			buf_ff <= 1'b1;
			act_ff <= 1'b0;
		end else if (clk_en_in) begin
			dout_ff <= nxt_dout;
			oe_n_ff <= nxt_oe_n;
			bg_ff <= 1'b1;
			buf_ff <= (nxt_mode != ADPD_MODE_FULL);
			act_ff <= (nxt_st != ADPD_DEV_IDLE);
		end
	end
	assign bus.dev_data = dout_ff;
	assign bus.dev_data_oe_n = oe_n_ff;
	assign bus.int_n = int_n_ff;
	assign bandgap_on_out = bg_ff;
	assign ref_buf_on_out = buf_ff;
	assign conv_active_out = act_ff;
	assign int_clk_sel_out = intclk_ff;
	assign mode_out = mode_ff;
endmodule : adpd_device

// ==== logic/adpd_host.sv ====
/*
 Host end: Avalon-MM slave with control, command, status and mask
 registers; drives write and read cycles on the parallel bus.
 Assumes the converter answers within the strobe length used here.
*/
`timescale 1ns/100ps
`include "adpd_params.svh"
module adpd_host #(
	parameter int STROBE_CYCLES = `ADPD_STROBE_CYCLES
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	adpd_bus_if.host bus,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out
);
	import adpd_pkg::*;

	// ==========================================
	// Interrupt pin synchroniser
	logic i1_ff, i2_ff, i3_ff, int_lvl_ff;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			i1_ff <= 1'b1;
			i2_ff <= 1'b1;
			i3_ff <= 1'b1;
			int_lvl_ff <= 1'b1;
		end else if (clk_en_in) begin
			i1_ff <= bus.int_n;
			i2_ff <= i1_ff;
			i3_ff <= i2_ff;
			if (i2_ff == i3_ff) begin
				int_lvl_ff <= i3_ff;
			end
		end
	end

	// ==========================================
	// Registers and bus cycles
	adpd_hst_t st_ff, nxt_st;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
	logic [11:0] res_ff, nxt_res;
	logic rd_cyc_ff, nxt_rd_cyc, hb_ff, nxt_hb;
	logic [7:0] cnt_ff, nxt_cnt;
	logic int_q_ff;
	logic sd_n_ff, nxt_sd_n;
	logic [31:0] rdata_ff, nxt_rdata;
	logic wait_ff, nxt_wait, irq_ff;
	logic req;
	assign req = avs_read_in | avs_write_in;
	always_comb begin
		nxt_st = st_ff;
		nxt_ctrl = ctrl_ff;
		nxt_stat = stat_ff;
		nxt_mask = mask_ff;
		nxt_res = res_ff;
		nxt_rd_cyc = rd_cyc_ff;
		nxt_hb = hb_ff;
		nxt_cnt = cnt_ff;
		nxt_sd_n = sd_n_ff;
		nxt_rdata = rdata_ff;
		nxt_wait = 1'b1;
		case (st_ff)
			ADPD_HST_IDLE: begin
				if (req && wait_ff) begin
					if (avs_address_in == `ADPD_REG_CMD) begin
						nxt_st = ADPD_HST_LOW;
						nxt_rd_cyc = avs_read_in;
						nxt_hb = 1'b0;
						nxt_cnt = 8'(STROBE_CYCLES * 4);
					end else begin
						nxt_wait = 1'b0;
						nxt_rdata = 32'h0;
						if (avs_address_in == `ADPD_REG_CTRL) begin
							nxt_rdata = {23'h0, sd_n_ff, ctrl_ff};
							if (avs_write_in) begin
								nxt_ctrl = avs_writedata_in[7:0];
								nxt_sd_n = avs_writedata_in[8];
							end
						end else if (avs_address_in == `ADPD_REG_STATUS) begin
							nxt_rdata = {30'h0, stat_ff};
							if (avs_write_in) begin
								nxt_stat = stat_ff & ~avs_writedata_in[1:0];
							end
						end else if (avs_address_in == `ADPD_REG_MASK) begin
							nxt_rdata = {30'h0, mask_ff};
							if (avs_write_in) begin
								nxt_mask = avs_writedata_in[1:0];
							end
						end
					end
				end
			end
			ADPD_HST_LOW: begin
				if (cnt_ff == 8'h00) begin
					if (rd_cyc_ff && !hb_ff) begin
						nxt_res[7:0] = bus.dev_data;
						nxt_hb = 1'b1;
						nxt_cnt = 8'(STROBE_CYCLES * 4);
					end else begin
						if (rd_cyc_ff) begin
							nxt_res[11:8] = bus.dev_data[3:0];
						end
						nxt_st = ADPD_HST_HIGH;
						nxt_cnt = 8'(STROBE_CYCLES);
					end
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			default: begin
				if (cnt_ff == 8'h00) begin
					nxt_st = ADPD_HST_IDLE;
					nxt_wait = 1'b0;
					nxt_rdata = {20'h0, res_ff};
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
		endcase
		if (int_q_ff && !int_lvl_ff) begin
			nxt_stat[`ADPD_ST_READY] = 1'b1;
		end
		if (st_ff == ADPD_HST_HIGH && cnt_ff == 8'h00) begin
			nxt_stat[`ADPD_ST_DONE] = 1'b1;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_ff <= ADPD_HST_IDLE;
			ctrl_ff <= `ADPD_CTRL_RST;
			stat_ff <= 2'h0;
			mask_ff <= `ADPD_MASK_RST;
			res_ff <= 12'h000;
			rd_cyc_ff <= 1'b0;
			hb_ff <= 1'b0;
			cnt_ff <= 8'h00;
			int_q_ff <= 1'b1;
			sd_n_ff <= 1'b1;
			rdata_ff <= 32'h0;
			wait_ff <= 1'b1;
			irq_ff <= 1'b0;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
			ctrl_ff <= nxt_ctrl;
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			res_ff <= nxt_res;
			rd_cyc_ff <= nxt_rd_cyc;
			hb_ff <= nxt_hb;
			cnt_ff <= nxt_cnt;
			int_q_ff <= int_lvl_ff;
			sd_n_ff <= nxt_sd_n;
			rdata_ff <= nxt_rdata;
			wait_ff <= nxt_wait;
			irq_ff <= |(nxt_stat & nxt_mask);
		end
	end
	logic strobe;
	assign strobe = (st_ff == ADPD_HST_LOW) && (cnt_ff > 8'(STROBE_CYCLES));
	assign bus.cs_n = (st_ff == ADPD_HST_IDLE);
	assign bus.wr_n = ~(strobe & ~rd_cyc_ff);
	assign bus.rd_n = ~(strobe & rd_cyc_ff);
	assign bus.hben = hb_ff;
	assign bus.host_data = ctrl_ff;
	assign bus.hw_shutdown_n = sd_n_ff;
	assign avs_readdata_out = rdata_ff;
	assign avs_waitrequest_out = wait_ff;
	assign irq_out = irq_ff;
endmodule : adpd_host

// ==== logic/adpd_params.svh ====
/*
 Constants for the power-down and coding block: control byte fields,
 power-mode codes, timing counts, register offsets of the host end.
 Assumes a 250 MHz system clock.
*/
`ifndef ADPD_PARAMS_SVH
`define ADPD_PARAMS_SVH
// Control byte fields
`define ADPD_CTL_PM_LO 6
`define ADPD_CTL_PM_HI 7
`define ADPD_CTL_BIP 3
`define ADPD_CTL_ACQ 5
// Power-mode codes
`define ADPD_PM_EXT_CLK 2'h0
`define ADPD_PM_INT_CLK 2'h1
`define ADPD_PM_STANDBY 2'h2
`define ADPD_PM_FULL 2'h3
// Timing: clock period, device conversion phases and host strobe length
`define ADPD_CLK_PERIOD_NS 4
`define ADPD_ACQ_TIME_NS 24
`define ADPD_CONV_TIME_NS 48
`define ADPD_ACQ_CYCLES ((`ADPD_ACQ_TIME_NS+`ADPD_CLK_PERIOD_NS-1)/`ADPD_CLK_PERIOD_NS)
`define ADPD_CONV_CYCLES ((`ADPD_CONV_TIME_NS+`ADPD_CLK_PERIOD_NS-1)/`ADPD_CLK_PERIOD_NS)
`define ADPD_STROBE_CYCLES 2
// Host register offsets (byte addresses)
`define ADPD_REG_CTRL 4'h0
`define ADPD_REG_CMD 4'h4
`define ADPD_REG_STATUS 4'h8
`define ADPD_REG_MASK 4'hc
`define ADPD_REG_RESULT 4'h4
// Reset values
`define ADPD_CTRL_RST 8'h00
`define ADPD_MASK_RST 2'h0
// Status bits
`define ADPD_ST_READY 0
`define ADPD_ST_DONE 1
`endif

// ==== logic/adpd_pkg.sv ====
/*
 Types for the power-down and coding block.
 Assumes adpd_params.svh holds the numeric constants.
*/
package adpd_pkg;
	typedef enum logic [1:0] {
		ADPD_MODE_RUN,
		ADPD_MODE_STANDBY,
		ADPD_MODE_FULL
	} adpd_mode_t;
	typedef enum logic [1:0] {
		ADPD_DEV_IDLE,
		ADPD_DEV_ACQ,
		ADPD_DEV_CONV
	} adpd_dev_t;
	typedef enum logic [1:0] {
		ADPD_HST_IDLE,
		ADPD_HST_LOW,
		ADPD_HST_HIGH
	} adpd_hst_t;
endpackage : adpd_pkg
